//--- src/lsr_pkg.sv
/*
 * Shared constants, register map and types for the linear sensor readout
 * sequencer. Assumes a 32-bit APB slave and a 20 MHz pclk domain.
 */
package lsr_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [11:0] LSR_OFS_CTRL   = 12'h000;
	localparam logic [11:0] LSR_OFS_STAT   = 12'h004;
	localparam logic [11:0] LSR_OFS_COUNT  = 12'h008;
	localparam logic [11:0] LSR_OFS_DATA   = 12'h00C;

	localparam int          LSR_CTRL_EN    = 0;
	localparam int          LSR_CTRL_LOG   = 1;
	localparam int          LSR_CTRL_FLUSH = 2;
	localparam logic [2:0]  LSR_CTRL_RST   = 3'h3;

	localparam int          LSR_ST_BUSY    = 0;
	localparam int          LSR_ST_TRACK   = 1;
	localparam int          LSR_ST_HOLDM   = 2;
	localparam int          LSR_ST_HOLDL   = 3;
	localparam int          LSR_ST_SHUT    = 4;
	localparam int          LSR_ST_OVF     = 5;
	localparam int          LSR_ST_CLRN    = 6;
	localparam int          LSR_ST_CNT_LO  = 8;
	localparam int          LSR_DATA_VLD   = 31;

	// ----------------------------------------------------------------
	// sequencer counts
	// ----------------------------------------------------------------
	localparam logic [7:0]  LSR_CNT_RST    = 8'h00;
	localparam logic [7:0]  LSR_FIRST_PIX  = 8'h01;
	localparam logic [7:0]  LSR_MAIN_LAST  = 8'h7F;
	localparam logic [7:0]  LSR_PIXELS     = 8'h80;
	localparam logic [7:0]  LSR_TRACK_CNT  = 8'h81;
	localparam logic [7:0]  LSR_FALL_CLR   = 8'h01;
	localparam logic [7:0]  LSR_FALL_REL   = 8'h02;
	localparam logic [7:0]  LSR_FALL_SAT   = 8'h03;
	localparam logic [15:0] LSR_DONE_RST   = 16'h0000;
	localparam int          LSR_FIFO_DEPTH = 16;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		LSR_IDLE  = 3'b001,
		LSR_READ  = 3'b010,
		LSR_TRACK = 3'b100
	} lsr_state_t;

	typedef struct packed {
		logic       restart;
		logic       tracking;
		logic       held;
		logic [7:0] pixel;
	} lsr_evt_t;

	localparam int          LSR_EVT_W      = $bits(lsr_evt_t);

	function automatic logic [7:0] lsr_sat_inc(input logic [7:0] v,
		input logic [7:0] lim);
		lsr_sat_inc = (v >= lim) ? lim : v + 8'h01;
	endfunction

endpackage

//--- src/lsr_fifo.sv
/*
 * Synchronous FIFO with valid/ready on both sides and a flush.
 * Assumes one clock and an active-low asynchronous reset.
 */
`timescale 1ns/1ps
module lsr_fifo #(
	parameter int WIDTH = 11,
	parameter int DEPTH = 16
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             flush,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_r;
	logic [AW-1:0]    rd_ptr_r;
	logic [AW:0]      count_r;
	wire              push = in_valid & in_ready;
	wire              pop  = out_valid & out_ready;

	assign in_ready  = (count_r < (AW+1)'(DEPTH));
	assign out_valid = (count_r != '0);
	assign out_data  = mem[rd_ptr_r];

	always_ff @(posedge clk)
	begin
		if (push)
			mem[wr_ptr_r] <= in_data;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
		end
		else if (flush)
		begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_r <= wr_ptr_r + AW'(1);
			if (pop)
				rd_ptr_r <= rd_ptr_r + AW'(1);
			count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // lsr_fifo

//--- src/lsr_seq.sv
/*
 * Readout and integration sequencer of a 128-pixel linear sensor, with an
 * APB register file and an event FIFO. Assumes the sensor clock, start and
 * shutter arrive as asynchronous pins, much slower than pclk.
 */
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/1ps
module lsr_seq
	import lsr_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        start_in,
	input  wire logic        sensor_clk_in,
	input  wire logic        shutter_suspend_in,
	output logic             hold_select_main,
	output logic             hold_select_last_pixel,
	output logic             integrator_clear_n,
	output logic             photodiode_connect,
	output logic      [7:0]  pixel_voltage_out_sel,
	output logic             pixel_track_out
);

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic sclk_s1_r;
	logic sclk_s2_r;
	logic sclk_s3_r;
	logic start_s1_r;
	logic start_s2_r;
	logic shut_s1_r;
	logic shut_s2_r;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sclk_s1_r  <= 1'b0;
			sclk_s2_r  <= 1'b0;
			sclk_s3_r  <= 1'b0;
			start_s1_r <= 1'b0;
			start_s2_r <= 1'b0;
			shut_s1_r  <= 1'b0;
			shut_s2_r  <= 1'b0;
		end
		else
		begin
			sclk_s1_r  <= sensor_clk_in;
			sclk_s2_r  <= sclk_s1_r;
			sclk_s3_r  <= sclk_s2_r;
			start_s1_r <= start_in;
			start_s2_r <= start_s1_r;
			shut_s1_r  <= shutter_suspend_in;
			shut_s2_r  <= shut_s1_r;
		end
	end

	// ----------------------------------------------------------------
	// registers and state
	// ----------------------------------------------------------------
	lsr_state_t  state_r;
	logic [7:0]  cnt_r;
	logic [7:0]  fall_r;
	logic        hold_m_r;
	logic        hold_l_r;
	logic        pend_r;
	logic        clr_n_r;
	logic [15:0] done_r;
	logic [2:0]  ctrl_r;
	logic        ovf_r;
	logic        flush_r;
	logic        conn_r;
	logic [7:0]  pix_r;
	logic        track_r;
	logic [31:0] prdata_r;
	logic        pready_r;
	logic        pslverr_r;

	// ----------------------------------------------------------------
	// sequencer decode
	// ----------------------------------------------------------------
	wire rise     = sclk_s2_r & ~sclk_s3_r;
	wire fall     = ~sclk_s2_r & sclk_s3_r;
	wire in_read  = (state_r == LSR_READ);
	wire trig     = rise & start_s2_r & ctrl_r[LSR_CTRL_EN];
	wire early    = in_read & (cnt_r < LSR_PIXELS);
	wire restart  = trig & early;
	wire fresh    = trig & ~early;
	wire step     = rise & ~trig & (state_r != LSR_IDLE);
	wire end_main = rise & ~trig & in_read & (cnt_r == LSR_MAIN_LAST);
	wire end_last = rise & ~trig & in_read & (cnt_r == LSR_PIXELS);

	// pixel index advances once per sensor clock, saturating past 128
	wire [7:0] cnt_nxt = trig ? LSR_FIRST_PIX :
		step ? lsr_sat_inc(cnt_r, LSR_TRACK_CNT) : cnt_r;

	// leaving the read state after pixel 128 is output
	wire lsr_state_t state_nxt = trig ? LSR_READ :
		end_last ? LSR_TRACK : state_r;

	wire read_nxt = (state_nxt == LSR_READ);

	// restart leaves both hold selects alone
	wire hold_m_nxt = fresh ? 1'b1 :
		end_main ? 1'b0 : hold_m_r;

	wire hold_l_nxt = (rise & pend_r) ? 1'b1 :
		end_last ? 1'b0 : hold_l_r;

	wire pend_nxt = fresh ? 1'b1 : (rise ? 1'b0 : pend_r);

	// falling edges of a fresh readout place the clear pulse
	wire [7:0] fall_nxt = fresh ? LSR_CNT_RST :
		fall ? lsr_sat_inc(fall_r, LSR_FALL_SAT) : fall_r;

	wire clr_n_nxt = (fall & (fall_r == LSR_FALL_CLR)) ? 1'b0 :
		(fall & (fall_r == LSR_FALL_REL)) ? 1'b1 : clr_n_r;

	// outside a readout pixel 1 is routed straight, unheld
	wire [7:0] pix_nxt   = read_nxt ? cnt_nxt : LSR_FIRST_PIX;
	wire       track_nxt = ~read_nxt;

	// ----------------------------------------------------------------
	// event log into the FIFO
	// ----------------------------------------------------------------
	lsr_evt_t evt;
	lsr_evt_t fifo_head;
	logic     fifo_in_ready;
	logic     fifo_out_valid;

	assign evt.restart  = restart;
	assign evt.tracking = track_nxt;
	assign evt.held     = read_nxt;
	assign evt.pixel    = pix_nxt;

	// a full FIFO drops the event instead of logging it; the lost event is flagged
	wire log_vld  = rise & (state_nxt != LSR_IDLE) & ctrl_r[LSR_CTRL_LOG];
	wire log_push = log_vld & fifo_in_ready;
	wire log_lost = log_vld & ~fifo_in_ready;

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	wire setup    = psel & ~penable;
	wire access   = psel & penable & pready_r;
	wire hit_ctrl = (paddr == LSR_OFS_CTRL);
	wire hit_stat = (paddr == LSR_OFS_STAT);
	wire hit_cnt  = (paddr == LSR_OFS_COUNT);
	wire hit_data = (paddr == LSR_OFS_DATA);
	wire mapped   = hit_ctrl | hit_stat | hit_cnt | hit_data;
	wire wr_ok    = access & pwrite & ~pslverr_r;
	wire wr_ctrl  = wr_ok & hit_ctrl;
	wire wr_stat  = wr_ok & hit_stat;

	// pop only when the word shown to the master was valid
	wire rd_pop = access & ~pwrite & hit_data & prdata_r[LSR_DATA_VLD];

	wire [31:0] stat_word = {16'h0000, cnt_r, 1'b0, ~clr_n_r, ovf_r,
		shut_s2_r, hold_l_r, hold_m_r, track_r, in_read};

	wire [31:0] data_word = {fifo_out_valid, {(31-LSR_EVT_W){1'b0}},
		fifo_head};

	wire [31:0] rd_mux = hit_ctrl ? {29'h00000000, ctrl_r} :
		hit_stat ? stat_word :
		hit_cnt  ? {16'h0000, done_r} :
		hit_data ? data_word : 32'h00000000;

	// hardware set wins over the software clear
	wire ovf_nxt = log_lost | (ovf_r & ~(wr_stat & pwdata[LSR_ST_OVF]));

	wire [15:0] done_nxt = end_last ? done_r + 16'h0001 : done_r;

	// ----------------------------------------------------------------
	// sequencer flops
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_r  <= LSR_IDLE;
			cnt_r    <= LSR_CNT_RST;
			fall_r   <= LSR_FALL_SAT;
			hold_m_r <= 1'b0;
			hold_l_r <= 1'b0;
			pend_r   <= 1'b0;
			clr_n_r  <= 1'b0;
			pix_r    <= LSR_FIRST_PIX;
			track_r  <= 1'b1;
			conn_r   <= 1'b1;
		end
		else
		begin
			state_r  <= state_nxt;
			cnt_r    <= cnt_nxt;
			fall_r   <= fall_nxt;
			hold_m_r <= hold_m_nxt;
			hold_l_r <= hold_l_nxt;
			pend_r   <= pend_nxt;
			clr_n_r  <= clr_n_nxt | (state_r == LSR_IDLE);
			pix_r    <= pix_nxt;
			track_r  <= track_nxt;
			conn_r   <= ~shut_s2_r;
		end
	end

	// ----------------------------------------------------------------
	// register file flops
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_r    <= LSR_CTRL_RST;
			flush_r   <= 1'b0;
			ovf_r     <= 1'b0;
			done_r    <= LSR_DONE_RST;
			prdata_r  <= 32'h00000000;
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
		end
		else
		begin
			if (wr_ctrl)
				ctrl_r <= {1'b0, pwdata[LSR_CTRL_LOG:LSR_CTRL_EN]};
			flush_r   <= wr_ctrl & pwdata[LSR_CTRL_FLUSH];
			ovf_r     <= ovf_nxt;
			done_r    <= done_nxt;
			prdata_r  <= (setup & ~pwrite) ? rd_mux : 32'h00000000;
			pready_r  <= setup;
			pslverr_r <= setup & ~mapped;
		end
	end

	// ----------------------------------------------------------------
	// event FIFO
	// ----------------------------------------------------------------
	lsr_fifo #(
		.WIDTH (LSR_EVT_W),
		.DEPTH (LSR_FIFO_DEPTH)
	) u_fifo (
		.clk       (pclk),
		.rst_n     (presetn),
		.flush     (flush_r),
		.in_valid  (log_push),
		.in_ready  (fifo_in_ready),
		.in_data   (evt),
		.out_valid (fifo_out_valid),
		.out_ready (rd_pop),
		.out_data  (fifo_head)
	);

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign prdata                 = prdata_r;
	assign pready                 = pready_r;
	assign pslverr                = pslverr_r;
	assign hold_select_main       = hold_m_r;
	assign hold_select_last_pixel = hold_l_r;
	assign integrator_clear_n     = clr_n_r;
	assign photodiode_connect     = conn_r;
	assign pixel_voltage_out_sel  = pix_r;
	assign pixel_track_out        = track_r;

endmodule // lsr_seq

//--- testbench/lsr_seq_monitor.sv
/* Checker on the sequencer's sensor-side ports.
   Assumes the controller model clocks the sensor at 8 pclk a period. */
`timescale 1ns/1ps
module lsr_seq_mon
	import lsr_pkg::*;
(
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic       shutter_suspend_in,
	input wire logic       hold_select_main,
	input wire logic       hold_select_last_pixel,
	input wire logic       integrator_clear_n,
	input wire logic       photodiode_connect,
	input wire logic [7:0] pixel_voltage_out_sel,
	input wire logic       pixel_track_out
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_rst;
		$rose(presetn) |-> !hold_select_main && !hold_select_last_pixel
			&& !integrator_clear_n;
	endproperty
	a_rst: assert property (p_rst) else $error("not in reset state");
	property p_hm_up;
		$rose(hold_select_main) |-> pixel_voltage_out_sel == LSR_FIRST_PIX
			&& !pixel_track_out;
	endproperty
	a_hm_up: assert property (p_hm_up) else $error("bad hold start");
	property p_hl_up;
		$rose(hold_select_main) |-> !hold_select_last_pixel[*8]
			##1 hold_select_last_pixel;
	endproperty
	a_hl_up: assert property (p_hl_up) else $error("late hold");
	property p_clr;
		$fell(integrator_clear_n) |-> pixel_voltage_out_sel == 8'h02
			##0 !integrator_clear_n[*8] ##1 integrator_clear_n;
	endproperty
	a_clr: assert property (p_clr) else $error("bad clear pulse");
	property p_hm_dn;
		$fell(hold_select_main) |-> pixel_voltage_out_sel == LSR_PIXELS;
	endproperty
	a_hm_dn: assert property (p_hm_dn) else $error("early sample");
	property p_hl_dn;
		$fell(hold_select_main) |-> hold_select_last_pixel[*8]
			##1 !hold_select_last_pixel;
	endproperty
	a_hl_dn: assert property (p_hl_dn) else $error("bad last sample");
	property p_trk;
		pixel_track_out |-> pixel_voltage_out_sel == LSR_FIRST_PIX
			&& !hold_select_main && !hold_select_last_pixel;
	endproperty
	a_trk: assert property (p_trk) else $error("bad tracking");
	property p_step;
		$changed(pixel_voltage_out_sel) && pixel_voltage_out_sel != LSR_FIRST_PIX
			|-> pixel_voltage_out_sel == $past(pixel_voltage_out_sel) + 8'h01;
	endproperty
	a_step: assert property (p_step) else $error("pixel skipped");
	property p_shut;
		shutter_suspend_in[*6] |-> !photodiode_connect;
	endproperty
	a_shut: assert property (p_shut) else $error("still integrating");
	property p_integ;
		!shutter_suspend_in[*6] |-> photodiode_connect;
	endproperty
	a_integ: assert property (p_integ) else $error("not integrating");
	c_start: cover property ($rose(hold_select_main));
	c_clear: cover property ($fell(integrator_clear_n));
	c_track: cover property ($rose(pixel_track_out));
endmodule // lsr_seq_mon

bind lsr_seq lsr_seq_mon lsr_seq_mon_i (.pclk, .presetn, .shutter_suspend_in,
	.hold_select_main, .hold_select_last_pixel, .integrator_clear_n,
	.photodiode_connect, .pixel_voltage_out_sel, .pixel_track_out);

//--- testbench/lsr_ctrl_model.sv
/* Behavioural sensor controller: clock, start and shutter pins.
   Assumes the bench steps it through run, start_req and shut_req. */
`timescale 1ns/1ps
module lsr_ctrl_model (
	input  wire logic pclk,
	input  wire logic run,
	input  wire logic start_req,
	input  wire logic shut_req,
	output logic      sensor_clk_in,
	output logic      start_in,
	output logic      shutter_suspend_in
);
	logic [1:0] ph_r = 2'h0;
	initial
	begin
		sensor_clk_in = 1'h0;
		start_in = 1'h0;
		shutter_suspend_in = 1'h0;
	end
	// clock stops low when idle; start changes on falls for setup and hold
	always @(posedge pclk)
	begin
		ph_r <= ph_r + 2'h1;
		if (ph_r == 2'h3 && (run || sensor_clk_in))
		begin
			sensor_clk_in <= !sensor_clk_in;
			if (sensor_clk_in)
				start_in <= start_req;
		end
		shutter_suspend_in <= shut_req;
	end
endmodule // lsr_ctrl_model

//--- testbench/lsr_seq_bench.sv
/* Self-checking bench for the sensor sequencer over APB and sensor pins.
   Assumes the controller model and the bound checker. */
`timescale 1ns/1ps
module lsr_seq_bench
	import lsr_pkg::*;
;
	logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
	logic        pwrite = 1'h0, run = 1'h0, start_req = 1'h0, shut_req = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic        pready, pslverr, start_in, sensor_clk_in, shutter_suspend_in;
	logic        hold_select_main, hold_select_last_pixel, integrator_clear_n;
	logic        photodiode_connect, pixel_track_out, e;
	logic [7:0]  pixel_voltage_out_sel;
	int          fails = 0, checked = 0;

	always #25 pclk = ~pclk;

	lsr_seq lsr_seq_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .start_in, .sensor_clk_in,
		.shutter_suspend_in, .hold_select_main, .hold_select_last_pixel,
		.integrator_clear_n, .photodiode_connect, .pixel_voltage_out_sel,
		.pixel_track_out);
	lsr_ctrl_model lsr_ctrl_model_i (.pclk, .run, .start_req, .shut_req,
		.sensor_clk_in, .start_in, .shutter_suspend_in);

	task give_verdict;
		if (fails == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task cmp(input logic [31:0] g, input logic [31:0] x);
		checked++;
		if (g !== x)
		begin
			$display("Error at %0t: got %h expected %h", $time, g, x);
			fails++;
		end
	endtask

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		i = 0;
		do
		begin
			@(posedge pclk);
			i++;
		end
		while (pready !== 1'h1 && i < 20);
		q = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (i >= 20)
		begin
			fails++;
			give_verdict;
		end
	endtask

	task rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
		apb(1'h0, a, 32'h0);
		cmp(q & m, x);
	endtask

	// outputs settle 3 pclk after a pin edge; look before the next fall acts
	task rise;
		int i;
		i = 0;
		while (sensor_clk_in && i < 40)
		begin
			@(posedge pclk);
			i++;
		end
		while (!sensor_clk_in && i < 40)
		begin
			@(posedge pclk);
			i++;
		end
		if (i >= 40)
		begin
			fails++;
			give_verdict;
		end
		repeat (4) @(posedge pclk);
	endtask

	task go;
		int i;
		start_req <= 1'h1;
		for (i = 0; i < 40 && !start_in; i++)
			@(posedge pclk);
		if (!start_in)
		begin
			fails++;
			give_verdict;
		end
		start_req <= 1'h0;
		rise();
	endtask

	// rs: the first start lands mid-readout, so holds stay and no clear
	task walk(input int n, input logic rs);
		logic [11:0] x;
		for (int p = 0; p < n; p++)
		begin
			if (p == 0)
				go();
			else
				rise();
			x = {p < 127, (p > 0 && p < 128) || (p == 0 && rs),
				!(p == 2 && !rs), p >= 128, 8'(p < 128 ? p + 1 : 1)};
			cmp({20'h0, hold_select_main, hold_select_last_pixel,
				integrator_clear_n, pixel_track_out,
				pixel_voltage_out_sel}, {20'h0, x});
		end
	endtask

	initial
	begin
		repeat (5) @(posedge pclk);
		cmp({hold_select_main, hold_select_last_pixel, integrator_clear_n},
			32'h0);
		presetn <= 1'h1;
		run <= 1'h1;
		rd(LSR_OFS_CTRL, 32'h7, 32'h3);
		rd(12'h010, 32'h0, 32'h0);
		cmp({31'h0, e}, 32'h1);
		walk(130, 1'h0);
		rd(LSR_OFS_COUNT, 32'hFFFF, 32'h1);
		walk(10, 1'h0);
		walk(130, 1'h1);
		rd(LSR_OFS_COUNT, 32'hFFFF, 32'h2);
		shut_req <= 1'h1;
		repeat (8) @(posedge pclk);
		cmp({31'h0, photodiode_connect}, 32'h0);
		shut_req <= 1'h0;
		repeat (8) @(posedge pclk);
		cmp({31'h0, photodiode_connect}, 32'h1);
		// far side stalled: no rises, so the full buffer only drains
		run <= 1'h0;
		repeat (16) @(posedge pclk);
		rd(LSR_OFS_STAT, 32'h20, 32'h20);
		for (int k = 0; k < LSR_FIFO_DEPTH; k++)
			rd(LSR_OFS_DATA, 32'h800007FF, 32'h80000101 + 32'(k));
		rd(LSR_OFS_DATA, 32'h80000000, 32'h0);
		apb(1'h1, LSR_OFS_STAT, 32'h20);
		rd(LSR_OFS_STAT, 32'h20, 32'h0);
		// sequencing off: a start is ignored and pixel 1 keeps tracking
		apb(1'h1, LSR_OFS_CTRL, 32'h2);
		run <= 1'h1;
		go();
		cmp({22'h0, hold_select_main, pixel_track_out,
			pixel_voltage_out_sel}, 32'h00000101);
		rd(LSR_OFS_DATA, 32'h800007FF, 32'h80000201);
		run <= 1'h0;
		repeat (16) @(posedge pclk);
		apb(1'h1, LSR_OFS_CTRL, 32'h7);
		rd(LSR_OFS_DATA, 32'h80000000, 32'h0);
		rd(LSR_OFS_CTRL, 32'h7, 32'h3);
		give_verdict;
	end
endmodule // lsr_seq_bench
